// file: design/host_link_irq_event_low.sv
// lower half of the host link interrupt event register with its mask
// assumes an APB master on clk and single-cycle event pulses from the link core
//
// Implementation choices: the placing of the registers and the APB slave port.

module host_link_irq_event_low (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic                             pready,
   output logic [31:0]                      prdata,
   output logic                             pslverr,
   input  wire irq_event_pkg::event_pulses_t events,
   input  wire irq_event_pkg::iso_summary_t  iso,
   output logic [31:0]                      event_and_mask,
   output logic                             irq
);
   import irq_event_pkg::*;
   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   wire acc      = psel & penable;
   wire wr       = acc & pwrite;
   wire rd       = acc & ~pwrite;
   wire sel_es   = hit(paddr, EVT_SET_OFS);
   wire sel_ec   = hit(paddr, EVT_CLR_OFS);
   wire sel_ms   = hit(paddr, MASK_SET_OFS);
   wire sel_mc   = hit(paddr, MASK_CLR_OFS);
   wire sel_is   = hit(paddr, IRQ_STAT_OFS);
   wire sel_im   = hit(paddr, IRQ_MASK_OFS);
   wire mapped   = sel_es | sel_ec | sel_ms | sel_mc | sel_is | sel_im;

   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

   // ---------------------------------------------------------------
   // event sources and software set/clear
   // ---------------------------------------------------------------
   // source order: 17,16,9,8,5,4,3,2,1,0
   logic [SRC_W-1:0] hw_set;
   logic [SRC_W-1:0] sw_set;
   logic [SRC_W-1:0] sw_clr;
   logic [SRC_W-1:0] flags;

   function automatic logic [SRC_W-1:0] pick(input logic [31:0] v);
      return {v[17], v[16], v[9], v[8], v[5:0]};
   endfunction

   assign hw_set = {events.bus_init_started_flag,
                    events.topology_id_done_flag,
                    events.atomic_reply_unacked_err,
                    events.buffered_write_host_fault,
                    events.reply_packet_stored,
                    events.request_packet_stored,
                    events.async_reply_rx_ctx,
                    events.async_req_rx_ctx,
                    events.reply_send_done,
                    events.request_send_done};
   // ones set or clear, zeros leave bits alone
   assign sw_set = (wr & sel_es) ? pick(pwdata) : SRC_ZERO;
   // a rising bus reset clears self-id complete, overriding its set
   wire bus_rise = hw_set[9] | sw_set[9];
   wire [SRC_W-1:0] set_all = (hw_set | sw_set) & ~{1'b0, bus_rise, 8'h00};
   assign sw_clr = ((wr & sel_ec) ? pick(pwdata) : SRC_ZERO)
                 | {1'b0, bus_rise, 8'h00};

   sticky_bits u_flags (
      .clk    (clk),
      .rst    (rst),
      .set_i  (set_all),
      .clr_i  (sw_clr),
      .flag_o (flags)
   );

   // ---------------------------------------------------------------
   // mask register
   // ---------------------------------------------------------------
   logic [31:0] mask_q;
   logic [31:0] mask_d;
   assign mask_d = (wr & sel_ms) ? (mask_q | (pwdata & MASK_MASK)) :
                   (wr & sel_mc) ? (mask_q & ~(pwdata & MASK_MASK)) : mask_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) mask_q <= MASK_RESET;
      else     mask_q <= mask_d;
   end

   // ---------------------------------------------------------------
   // live event view
   // ---------------------------------------------------------------
   wire rx_sum = |(iso.rx_event & iso.rx_mask);
   wire tx_sum = |(iso.tx_event & iso.tx_mask);
   logic [31:0] evt_view;
   // reserved 15..10 stay zero
   assign evt_view = {14'h0000, flags[9], flags[8], 6'h00, flags[7], flags[6],
                      rx_sum, tx_sum, flags[5:0]};
   assign event_and_mask = evt_view & mask_q;
   wire gated = mask_q[BIT_GATE] & |(event_and_mask & ~(32'h1 << BIT_GATE));

   // ---------------------------------------------------------------
   // block interrupt status, cleared by read, and its mask
   // ---------------------------------------------------------------
   logic [1:0] ist_q;
   logic [1:0] ist_d;
   logic [1:0] imask_q;
   wire  [1:0] ist_ev = {gated, pslverr};
   assign ist_d = ist_ev | ((rd & sel_is) ? SUM_RESET : ist_q);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ist_q   <= SUM_RESET;
         imask_q <= SUM_RESET;
      end else begin
         ist_q   <= ist_d;
         imask_q <= (wr & sel_im) ? pwdata[1:0] : imask_q;
      end
   end
   assign irq = |(ist_q & imask_q);

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   wire [31:0] rd_mux = sel_es ? evt_view :
                        sel_ec ? event_and_mask :
                        (sel_ms | sel_mc) ? mask_q :
                        sel_is ? {30'h0, ist_q} :
                        sel_im ? {30'h0, imask_q} : 32'h0;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) prdata <= EVT_RESET;
      else if (psel & ~penable & ~pwrite) prdata <= rd_mux;
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   bus_init_set_a: assert property (events.bus_init_started_flag |=> evt_view[17])
      else $error("bus reset event not latched");
   topo_done_set_a: assert property (events.topology_id_done_flag & ~bus_rise |=> evt_view[16])
      else $error("self id event not latched");
   topo_cleared_a: assert property (bus_rise |=> ~evt_view[16])
      else $error("self id not cleared by bus reset");
   reserved_zero_a: assert property (evt_view[15:10] == 6'h00)
      else $error("reserved bits nonzero");
   atomic_err_a: assert property (events.atomic_reply_unacked_err |=> evt_view[9] [*1])
      else $error("lock error not latched");
   write_fault_a: assert property (events.buffered_write_host_fault |=> evt_view[8])
      else $error("posted write fault not latched");
   rx_summary_a: assert property (evt_view[7] == |(iso.rx_event & iso.rx_mask))
      else $error("rx summary wrong");
   tx_summary_a: assert property (evt_view[6] == |(iso.tx_event & iso.tx_mask))
      else $error("tx summary wrong");
   send_done_a: assert property (events.request_send_done |=> evt_view[0])
      else $error("request tx done not latched");
   clear_read_a: assert property (psel & ~penable & ~pwrite & sel_ec |=> prdata == $past(event_and_mask))
      else $error("clear address read wrong");
   gate_off_a: assert property (~mask_q[BIT_GATE] |=> ~ist_q[1] or $past(ist_q[1]))
      else $error("interrupt raised with gate closed");
   sw_clear_a: assert property (wr & sel_ec & pwdata[0] & ~events.request_send_done |=> ~evt_view[0])
      else $error("software clear ignored");

   // ---------------------------------------------------------------
   // assertions: per-source latching of the dma and packet events
   // ---------------------------------------------------------------
   // each source pulse must show in the event view one cycle later
   reply_pkt_set_a: assert property (events.reply_packet_stored |=> evt_view[5])
      else $error("reply packet event not latched");
   req_pkt_set_a: assert property (events.request_packet_stored |=> evt_view[4])
      else $error("request packet event not latched");
   reply_rx_set_a: assert property (events.async_reply_rx_ctx |=> evt_view[3])
      else $error("reply rx context event not latched");
   req_rx_set_a: assert property (events.async_req_rx_ctx |=> evt_view[2])
      else $error("request rx context event not latched");
   reply_tx_set_a: assert property (events.reply_send_done |=> evt_view[1])
      else $error("reply tx done not latched");

   // ---------------------------------------------------------------
   // assertions: bus reset and self id ordering
   // ---------------------------------------------------------------
   // self id completion seen without a bus reset beside it
   sequence topo_alone_s;
      events.topology_id_done_flag & ~bus_rise;
   endsequence
   // bus reset reported by the phy
   sequence bus_hit_s;
      events.bus_init_started_flag;
   endsequence
   // both reported in one cycle
   sequence both_hit_s;
      events.topology_id_done_flag & events.bus_init_started_flag;
   endsequence
   // a later bus reset wipes an earlier self id completion
   property topo_then_bus_p;
      topo_alone_s ##1 bus_hit_s |=> evt_view[17] & ~evt_view[16];
   endproperty
   // a simultaneous pair leaves only the bus reset bit
   property both_hit_p;
      both_hit_s |=> evt_view[17] & ~evt_view[16];
   endproperty
   topo_then_bus_a: assert property (topo_then_bus_p)
      else $error("self id survived a later bus reset");
   both_hit_a: assert property (both_hit_p)
      else $error("self id survived a simultaneous bus reset");
   // a software set of the bus reset bit knocks out self id as well
   sw_bus_set_a: assert property (wr & sel_es & pwdata[BIT_BUS_INIT] |=> evt_view[17] & ~evt_view[16])
      else $error("software bus reset left self id set");

   // ---------------------------------------------------------------
   // assertions: register view and read paths
   // ---------------------------------------------------------------
   // the upper half belongs to another block and reads zero here
   upper_zero_a: assert property (evt_view[31:18] == 14'h0000)
      else $error("upper event bits nonzero");
   // set address returns the plain event view
   set_read_a: assert property (psel & ~penable & ~pwrite & sel_es |=> prdata == $past(evt_view))
      else $error("set address read wrong");
   // both mask addresses return the mask
   mask_read_a: assert property (psel & ~penable & ~pwrite & (sel_ms | sel_mc) |=> prdata == $past(mask_q))
      else $error("mask read wrong");
   // read data stays put through the access phase
   prdata_hold_a: assert property (psel & penable |=> $stable(prdata))
      else $error("read data moved after access");
   // zero wait states
   pready_high_a: assert property (pready)
      else $error("ready low");
   // mapped addresses never signal an error
   slverr_mapped_a: assert property (acc & mapped |-> ~pslverr)
      else $error("error on mapped address");

   // ---------------------------------------------------------------
   // assertions: software set and clear
   // ---------------------------------------------------------------
   // a one written to the set address turns the bit on
   sw_set_a: assert property (wr & sel_es & pwdata[0] |=> evt_view[0])
      else $error("software set ignored");
   // only a one at the clear address can take set bit 0 down
   sticky_hold_a: assert property (evt_view[0] & ~(wr & sel_ec & pwdata[0]) |=> evt_view[0])
      else $error("event bit lost without clear");
   // a clear bit stays clear without a source or a set
   idle_keep_a: assert property (~evt_view[0] & ~events.request_send_done & ~(wr & sel_es & pwdata[0])
                                 |=> ~evt_view[0])
      else $error("event bit rose on its own");
   // writes never reach the reserved bits
   reserved_write_a: assert property (wr & sel_es |=> evt_view[15:10] == 6'h00)
      else $error("reserved bits took a write");
   // gate bit follows mask set and clear
   mask_set_a: assert property (wr & sel_ms & pwdata[BIT_GATE] |=> mask_q[BIT_GATE])
      else $error("gate not set");
   mask_clr_a: assert property (wr & sel_mc & pwdata[BIT_GATE] |=> ~mask_q[BIT_GATE])
      else $error("gate not cleared");

   // ---------------------------------------------------------------
   // assertions: interrupt gate and status
   // ---------------------------------------------------------------
   // a closed gate blocks every event from the interrupt path
   gate_blocks_a: assert property (~mask_q[BIT_GATE] |-> ~gated)
      else $error("gated interrupt with gate closed");
   // an open gate with an unmasked event records status
   gate_raise_a: assert property (gated |=> ist_q[1])
      else $error("gated interrupt not recorded");
   // status holds until it is read
   stat_hold_a: assert property (ist_q[1] & ~(rd & sel_is) |=> ist_q[1])
      else $error("status dropped without read");
   // a read with nothing pending empties the status
   stat_clear_a: assert property (rd & sel_is & ~gated |=> ist_q == SUM_RESET)
      else $error("status not cleared by read");
   // recorded and enabled status drives the pin
   irq_path_a: assert property (ist_q[1] & imask_q[1] |-> irq)
      else $error("interrupt pin low with enabled status");
endmodule

// file: common/irq_event_pkg.sv
// package for the lower half of the host link interrupt event register
// assumes a single clock domain and an APB register bus with 32-bit data
package irq_event_pkg;
   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] EVT_SET_OFS    = 8'h80;
   localparam logic [7:0] EVT_CLR_OFS    = 8'h84;
   localparam logic [7:0] MASK_SET_OFS   = 8'h88;
   localparam logic [7:0] MASK_CLR_OFS   = 8'h8C;
   localparam logic [7:0] IRQ_STAT_OFS   = 8'hC0;
   localparam logic [7:0] IRQ_MASK_OFS   = 8'hC4;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int BIT_BUS_INIT   = 17;
   localparam int BIT_TOPO_DONE  = 16;
   localparam int BIT_ATOMIC_ERR = 9;
   localparam int BIT_WRITE_FLT  = 8;
   localparam int BIT_TIMED_RX   = 7;
   localparam int BIT_TIMED_TX   = 6;
   localparam int BIT_GATE       = 31;
   localparam int EVT_W          = 18;
   localparam int SRC_W          = 10;
   localparam int ISO_W          = 8;

   // latched bits of the lower half: 17,16,9,8,5..0
   localparam logic [31:0] LATCHED_MASK = 32'h0003_033F;
   localparam logic [31:0] MASK_MASK    = 32'h8003_03FF;
   localparam logic [31:0] EVT_RESET    = 32'h0000_0000;
   localparam logic [31:0] MASK_RESET   = 32'h0000_0000;
   localparam logic [1:0]  SUM_RESET    = 2'h0;
   localparam logic [SRC_W-1:0] SRC_ZERO = 10'h000;

   // event pulses from the link core
   typedef struct packed {
      logic bus_init_started_flag;
      logic topology_id_done_flag;
      logic atomic_reply_unacked_err;
      logic buffered_write_host_fault;
      logic reply_packet_stored;
      logic request_packet_stored;
      logic async_reply_rx_ctx;
      logic async_req_rx_ctx;
      logic reply_send_done;
      logic request_send_done;
   } event_pulses_t;

   // isochronous per-context event and mask vectors
   typedef struct packed {
      logic [ISO_W-1:0] rx_event;
      logic [ISO_W-1:0] rx_mask;
      logic [ISO_W-1:0] tx_event;
      logic [ISO_W-1:0] tx_mask;
   } iso_summary_t;
endpackage

// file: design/sticky_bits.sv
// sticky event bits with set-wins-over-clear
// assumes synchronous pulse inputs on clk
module sticky_bits (
   input  wire logic                            clk,
   input  wire logic                            rst,
   input  wire logic [irq_event_pkg::SRC_W-1:0] set_i,
   input  wire logic [irq_event_pkg::SRC_W-1:0] clr_i,
   output logic      [irq_event_pkg::SRC_W-1:0] flag_o
);
   import irq_event_pkg::*;

   // ---------------------------------------------------------------
   // per-bit flops
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < SRC_W; g++) begin : g_bit
         logic bit_q;
         // set beats clear in the same cycle
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               bit_q <= 1'b0;
            end else if (set_i[g]) begin
               bit_q <= 1'b1;
            end else if (clr_i[g]) begin
               bit_q <= 1'b0;
            end
         end
         // one process per bit, each owning its own flop
         assign flag_o[g] = bit_q;
      end
   endgenerate
endmodule

// file: verification/tb_host_link_irq_event_low.sv
// testbench for the lower half of the host link interrupt event register
// assumes the design package is compiled first and the block answers on APB
module tb_host_link_irq_event_low;
   import irq_event_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic          clk = 1'b0;
   logic          rst = 1'b1;
   logic          psel = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite = 1'b0;
   logic [7:0]    paddr = 8'h00;
   logic [31:0]   pwdata = 32'h0000_0000;
   logic          pready;
   logic [31:0]   prdata;
   logic          pslverr;
   event_pulses_t events = '0;
   iso_summary_t  iso = '0;
   logic [31:0]   event_and_mask;
   logic          irq;
   int            error_cnt = 0;
   int            num_checks = 0;
   int            pos [10] = '{17, 16, 9, 8, 5, 4, 3, 2, 1, 0};
   logic [31:0]   rd;
   logic          er;

   // 100 MHz clock
   always #5 clk = ~clk;

   host_link_irq_event_low i_host_link_irq_event_low (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .events(events),
      .iso(iso), .event_and_mask(event_and_mask), .irq(irq));

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one apb transfer: setup, then access held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         error_cnt++;
         end_sim();
      end
   endtask

   // one-cycle pulse on the event inputs
   task automatic pulse(input logic [9:0] v);
      @(posedge clk);
      events <= event_pulses_t'(v);
      @(posedge clk);
      events <= '0;
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, 8'h80, 32'h0); chk(rd, 32'h0000_0000);
      apb(1'b0, 8'h88, 32'h0); chk(rd, 32'h0000_0000);
      // each source sets only its own bit
      for (int i = 0; i < 10; i++) begin
         apb(1'b1, 8'h84, 32'hFFFF_FFFF);
         pulse(10'h200 >> i);
         apb(1'b0, 8'h80, 32'h0); chk(rd, 32'h1 << pos[i]);
      end
      // bus reset knocks out the topology flag, also when both arrive together
      apb(1'b1, 8'h84, 32'hFFFF_FFFF);
      pulse(10'h100);
      pulse(10'h200);
      apb(1'b0, 8'h80, 32'h0); chk(rd, 32'h0002_0000);
      apb(1'b1, 8'h84, 32'hFFFF_FFFF);
      pulse(10'h300);
      apb(1'b0, 8'h80, 32'h0); chk(rd, 32'h0002_0000);
      // software set and clear, reserved and live bits untouched
      apb(1'b1, 8'h84, 32'hFFFF_FFFF);
      apb(1'b1, 8'h80, 32'hFFFF_FFFF);
      apb(1'b0, 8'h80, 32'h0); chk(rd, 32'h0002_033F);
      apb(1'b1, 8'h84, 32'h0000_0001);
      apb(1'b1, 8'h80, 32'h0000_0000);
      apb(1'b0, 8'h80, 32'h0); chk(rd, 32'h0002_033E);
      // clear address reads events and mask
      apb(1'b1, 8'h88, 32'h0000_0005);
      apb(1'b0, 8'h84, 32'h0); chk(rd, 32'h0000_0004);
      chk(event_and_mask, 32'h0000_0004);
      apb(1'b0, 8'h8C, 32'h0); chk(rd, 32'h0000_0005);
      // live isochronous summaries
      apb(1'b1, 8'h84, 32'hFFFF_FFFF);
      iso <= '{rx_event: 8'h81, rx_mask: 8'h01, tx_event: 8'h10, tx_mask: 8'h01};
      apb(1'b0, 8'h80, 32'h0); chk(rd, 32'h0000_0080);
      iso.tx_mask <= 8'h10;
      apb(1'b0, 8'h80, 32'h0); chk(rd, 32'h0000_00C0);
      iso <= '0;
      apb(1'b0, 8'h80, 32'h0); chk(rd, 32'h0000_0000);
      // interrupt needs the global gate
      apb(1'b1, 8'hC4, 32'h0000_0002);
      pulse(10'h001);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, 8'h88, 32'h8000_0000);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, 8'h8C, 32'h8000_0000);
      apb(1'b0, 8'hC0, 32'h0); chk(rd, 32'h0000_0002);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      // unmapped address refused and recorded
      apb(1'b0, 8'h10, 32'h0); chk({er, rd[30:0]}, 32'h8000_0000);
      apb(1'b0, 8'hC0, 32'h0); chk(rd, 32'h0000_0001);
      end_sim();
   end
endmodule
